//--- shared/aif_pkg.sv
// Package: register map, field positions and event carrier for the flag block
package aif_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_FLAG_STATUS_A = 16'h3010;
    localparam logic [15:0] ADDR_FLAG_STATUS_B = 16'h3014;
    localparam logic [15:0] ADDR_CUSTOM_GEN    = 16'h209C;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_FLAG_STATUS = 32'h0000_0000;
    localparam logic [31:0] RST_CUSTOM_GEN  = 32'h0000_0010;

    // ------------------------------------------------------------
    // Field positions in the flag status word
    // ------------------------------------------------------------
    localparam int FLAG_WIDTH              = 13;
    localparam int POS_CONVERSION_DONE     = 0;
    localparam int POS_IMPEDANCE_DONE      = 1;
    localparam int POS_FILTER_READY        = 2;
    localparam int POS_TEMP_DONE           = 3;
    localparam int POS_LOWER_LIMIT_FAULT   = 4;
    localparam int POS_UPPER_LIMIT_FAULT   = 5;
    localparam int POS_DELTA_FAULT         = 6;
    localparam int POS_MEAN_DONE           = 7;
    localparam int POS_VARIANCE_DONE       = 8;
    localparam int POS_CUSTOM_IRQ0         = 9;
    localparam int CUSTOM_COUNT            = 4;

    // Generator register trigger field occupies bits 3..0
    localparam int GEN_TRIG_LSB = 0;

    // ------------------------------------------------------------
    // Measurement event carrier, one-cycle pulses
    // ------------------------------------------------------------
    typedef struct packed {
        logic variance_done;
        logic mean_done;
        logic delta_fail;
        logic max_fail;
        logic min_fail;
        logic temp_done;
        logic filter_ready;
        logic impedance_done;
        logic conversion_done;
    } aif_evt_s;

endpackage

//--- core/aif_flags.sv
// Interrupt flag status word (low half) and sequencer custom interrupt generator
module aif_flags (
    // Clock, reset, enable
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // Measurement events, one-cycle pulses
    input  wire aif_pkg::aif_evt_s evt,
    // Per-bit clear requests from the clear logic
    input  wire logic [12:0]      flag_clr,
    // Sequencer register write port
    input  wire logic             seq_wr,
    input  wire logic [15:0]      seq_addr,
    input  wire logic [31:0]      seq_wdata,
    // Host serial register port
    input  wire logic             host_wr,
    input  wire logic             host_rd,
    input  wire logic [15:0]      host_addr,
    input  wire logic [31:0]      host_wdata,
    output logic      [31:0]      host_rdata,
    output logic                  host_rvalid,
    // Flag word and generator register for neighbouring logic
    output logic      [31:0]      interrupt_flag_status,
    output logic      [31:0]      custom_interrupt_generator
);

    // ------------------------------------------------------------
    // Flag state and generator trigger bits
    // ------------------------------------------------------------
    logic [12:0] flags;
    logic [12:0] next_flags;
    logic [3:0]  gen_trig;
    logic [3:0]  next_gen_trig;
    logic [12:0] flag_set;
    logic        seq_gen_wr;
    logic [3:0]  seq_trig;
    logic [31:0] next_rdata;
    logic        next_rvalid;

    // Only the sequencer port can reach the generator; host writes go nowhere
    assign seq_gen_wr = seq_wr && (seq_addr == aif_pkg::ADDR_CUSTOM_GEN);
    assign seq_trig   = seq_gen_wr ? seq_wdata[aif_pkg::GEN_TRIG_LSB +: 4] : 4'h0;

    // Set vector assembled by field position
    always_comb begin
        flag_set = '0;
        flag_set[aif_pkg::POS_CONVERSION_DONE]   = evt.conversion_done;
        flag_set[aif_pkg::POS_IMPEDANCE_DONE]    = evt.impedance_done;
        flag_set[aif_pkg::POS_FILTER_READY]      = evt.filter_ready;
        flag_set[aif_pkg::POS_TEMP_DONE]         = evt.temp_done;
        flag_set[aif_pkg::POS_LOWER_LIMIT_FAULT] = evt.min_fail;
        flag_set[aif_pkg::POS_UPPER_LIMIT_FAULT] = evt.max_fail;
        flag_set[aif_pkg::POS_DELTA_FAULT]       = evt.delta_fail;
        flag_set[aif_pkg::POS_MEAN_DONE]         = evt.mean_done;
        flag_set[aif_pkg::POS_VARIANCE_DONE]     = evt.variance_done;
        flag_set[aif_pkg::POS_CUSTOM_IRQ0 +: aif_pkg::CUSTOM_COUNT] = seq_trig;
    end

    // Sticky flags; a set in the clear cycle wins so no event is lost
    always_comb begin
        next_flags    = (flags & ~flag_clr) | flag_set;
        next_gen_trig = (gen_trig & ~flag_clr[aif_pkg::POS_CUSTOM_IRQ0 +: 4]) | seq_trig;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flags    <= aif_pkg::RST_FLAG_STATUS[12:0];
            gen_trig <= aif_pkg::RST_CUSTOM_GEN[3:0];
        end else if (clk_en) begin
            flags    <= next_flags;
            gen_trig <= next_gen_trig;
        end
    end

    // ------------------------------------------------------------
    // Host read path, answer one edge after the request
    // ------------------------------------------------------------
    // Generator reads from the host return zero: the value carries no meaning there
    always_comb begin
        next_rdata  = 32'h0000_0000;
        next_rvalid = host_rd;
        if (host_rd) begin
            unique case (host_addr)
                aif_pkg::ADDR_FLAG_STATUS_A: next_rdata = {19'h0, next_flags};
                aif_pkg::ADDR_FLAG_STATUS_B: next_rdata = {19'h0, next_flags};
                aif_pkg::ADDR_CUSTOM_GEN:    next_rdata = 32'h0000_0000;
                default:                     next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            host_rdata  <= 32'h0000_0000;
            host_rvalid <= 1'b0;
        end else if (clk_en) begin
            host_rdata  <= next_rdata;
            host_rvalid <= next_rvalid;
        end
    end

    // Reserved upper generator bits are constant, read-only
    assign interrupt_flag_status      = {19'h0, flags};
    assign custom_interrupt_generator = {aif_pkg::RST_CUSTOM_GEN[31:4], gen_trig};

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence seq_gen_write;
        clk_en && seq_gen_wr && seq_wdata[0];
    endsequence

    sequence custom0_up;
        interrupt_flag_status[aif_pkg::POS_CUSTOM_IRQ0] && custom_interrupt_generator[0];
    endsequence

    custom_trigger_a: assert property (@(posedge clock) disable iff (sys_rst)
        seq_gen_write |=> custom0_up)
        else $error("custom trigger 0 did not raise status");

    host_write_ignored_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && host_wr && !seq_gen_wr && flag_clr == 13'h0)
        |=> $stable(custom_interrupt_generator))
        else $error("host write changed generator register");

    conv_done_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && evt.conversion_done) |=> interrupt_flag_status[0])
        else $error("conversion event lost");

    set_beats_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && evt.delta_fail && flag_clr[6]) |=> interrupt_flag_status[6])
        else $error("clear beat a simultaneous delta event");

    sticky_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && flags[4] && !flag_clr[4]) |=> interrupt_flag_status[4])
        else $error("lower limit flag dropped without clear");

    upper_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && !flags[5] && !evt.max_fail) |=> !interrupt_flag_status[5])
        else $error("upper limit flag rose without a fault");

    copies_match_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && host_rd && host_addr == aif_pkg::ADDR_FLAG_STATUS_B)
        |=> host_rvalid && host_rdata == interrupt_flag_status)
        else $error("second flag copy differs");

    gen_read_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && host_rd && host_addr == aif_pkg::ADDR_CUSTOM_GEN)
        |=> host_rdata == 32'h0000_0000)
        else $error("host generator read returned data");

    reserved_const_a: assert property (@(posedge clock) disable iff (sys_rst)
        custom_interrupt_generator[31:4] == 28'h0000001)
        else $error("generator reserved bits changed");

    temp_done_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && evt.temp_done) |=> interrupt_flag_status[3] [*1] ##1 1)
        else $error("temperature flag not set");

    filter_ready_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && evt.filter_ready) |=> interrupt_flag_status[aif_pkg::POS_FILTER_READY])
        else $error("filter ready event lost");

    impedance_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && evt.impedance_done) |=> interrupt_flag_status[aif_pkg::POS_IMPEDANCE_DONE])
        else $error("impedance result event lost");

    delta_fault_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && evt.delta_fail) |=> interrupt_flag_status[aif_pkg::POS_DELTA_FAULT])
        else $error("delta fault event lost");

    upper_limit_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && evt.max_fail) |=> interrupt_flag_status[aif_pkg::POS_UPPER_LIMIT_FAULT])
        else $error("upper limit fault lost");

    lower_limit_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && evt.min_fail) |=> interrupt_flag_status[aif_pkg::POS_LOWER_LIMIT_FAULT])
        else $error("lower limit fault lost");

    mean_done_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && evt.mean_done) |=> interrupt_flag_status[aif_pkg::POS_MEAN_DONE])
        else $error("mean result event lost");

    variance_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && evt.variance_done) |=> interrupt_flag_status[aif_pkg::POS_VARIANCE_DONE])
        else $error("variance result event lost");

    // Every trigger bit is checked on its own, since a swapped pair would pass a bit 0 check
    for (genvar n = 0; n < aif_pkg::CUSTOM_COUNT; n++) begin : g_custom_chk
        custom_map_a: assert property (@(posedge clock) disable iff (sys_rst)
            (clk_en && seq_gen_wr && seq_wdata[n])
            |=> interrupt_flag_status[aif_pkg::POS_CUSTOM_IRQ0 + n]
                && custom_interrupt_generator[n])
            else $error("custom trigger missed its status bit");

        custom_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
            (clk_en && !flags[aif_pkg::POS_CUSTOM_IRQ0 + n] && !seq_trig[n])
            |=> !interrupt_flag_status[aif_pkg::POS_CUSTOM_IRQ0 + n])
            else $error("custom status rose without a sequencer write");
    end

    // Only a committed sequencer write or a clear may move the generator
    gen_seq_only_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && !seq_gen_wr && flag_clr[12:9] == 4'h0)
        |=> $stable(custom_interrupt_generator))
        else $error("generator changed without a sequencer write");

    copy_a_match_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && host_rd && host_addr == aif_pkg::ADDR_FLAG_STATUS_A)
        |=> host_rvalid && host_rdata == interrupt_flag_status)
        else $error("first flag copy differs");

    // Read valid is a single pulse; a stuck valid would let the host take stale data
    rvalid_pulse_a: assert property (@(posedge clock) disable iff (sys_rst)
        (clk_en && !host_rd) |=> !host_rvalid)
        else $error("read valid stayed high without a read");

    // A low enable freezes everything, so events in that cycle are lost on purpose
    freeze_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !clk_en |=> $stable(interrupt_flag_status) && $stable(custom_interrupt_generator)
            && $stable(host_rdata) && $stable(host_rvalid))
        else $error("state moved while the clock enable was low");

endmodule

//--- tb/aif_seq_model.sv
// Sequencer model: the only party that commits writes to the generator register
module aif_seq_model (
    // Clock
    input  wire logic        clock,
    // Sequencer write port
    output logic             seq_wr,
    output logic      [15:0] seq_addr,
    output logic      [31:0] seq_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus starts at zero and after a write carries the inverted address and data, so a stale value is never mistaken for data
    initial begin
        seq_wr    = 1'b0;
        seq_addr  = 16'h0000;
        seq_wdata = 32'h0000_0000;
    end

    // One-cycle write strobe, launched and dropped on rising edges
    task automatic write(input logic [15:0] addr, input logic [31:0] data);
        @(posedge clock);
        seq_wr    <= 1'b1;
        seq_addr  <= addr;
        seq_wdata <= data;
        @(posedge clock);
        seq_wr    <= 1'b0;
        seq_addr  <= ~addr;
        seq_wdata <= ~data;
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the flag status word and custom interrupt generator
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Stimulus signals
    // ------------------------------------------------------------
    logic clock = 0, sys_rst = 1, clk_en = 1, host_wr = 0, host_rd = 0;
    aif_pkg::aif_evt_s evt = '0;
    logic [12:0] flag_clr = '0;
    logic [15:0] host_addr = 16'h0000, seq_addr;
    logic [31:0] host_wdata = 32'h0000_0000, seq_wdata, host_rdata, status, gen, rd;
    logic seq_wr, host_rvalid;
    int failures = 0, n_tests = 0;

    always #2 clock = ~clock;

    aif_seq_model i_aif_seq_model (.clock(clock), .seq_wr(seq_wr), .seq_addr(seq_addr),
        .seq_wdata(seq_wdata));
    aif_flags i_aif_flags (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .evt(evt),
        .flag_clr(flag_clr), .seq_wr(seq_wr), .seq_addr(seq_addr), .seq_wdata(seq_wdata),
        .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .interrupt_flag_status(status), .custom_interrupt_generator(gen));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Read answers on the edge that takes the request, one cycle after it is driven
    task automatic host_read(input logic [15:0] addr, output logic [31:0] data);
        @(posedge clock);
        host_rd   <= 1'b1;
        host_addr <= addr;
        @(posedge clock);
        host_rd <= 1'b0;
        #1;
        check("rvalid", {31'h0, host_rvalid}, 32'h1);
        data = host_rdata;
    endtask

    // Clear pulse on chosen status bits
    task automatic clear(input logic [12:0] bits);
        @(posedge clock);
        flag_clr <= bits;
        @(posedge clock);
        flag_clr <= '0;
        #1;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Whole run is about 130 cycles (about 500 ns); this leaves wide margin
    initial begin
        #20000;
        failures++;
        summarize();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        check("gen reset", gen, 32'h0000_0010);
        host_read(aif_pkg::ADDR_FLAG_STATUS_A, rd);
        check("copy a reset", rd, 32'h0000_0000);
        host_read(aif_pkg::ADDR_FLAG_STATUS_B, rd);
        check("copy b reset", rd, 32'h0000_0000);
        $display("test reset done");
        // Each event lands on its own bit, holds, then clears
        for (int i = 0; i < 9; i++) begin
            @(posedge clock);
            evt <= aif_pkg::aif_evt_s'(9'h001 << i);
            @(posedge clock);
            evt <= '0;
            repeat (3) @(posedge clock);
            #1;
            check("event bit", status, 32'h1 << i);
            host_read(aif_pkg::ADDR_FLAG_STATUS_B, rd);
            check("event read", rd, 32'h1 << i);
            clear(13'h1 << i);
            check("event clear", status, 32'h0);
        end
        $display("test events done");
        // Gated clock enable drops the event
        @(posedge clock);
        clk_en <= 1'b0;
        evt    <= aif_pkg::aif_evt_s'(9'h001);
        @(posedge clock);
        clk_en <= 1'b1;
        evt    <= '0;
        #1;
        check("gated event", status, 32'h0);
        // Set and clear on one edge: the set wins
        @(posedge clock);
        evt      <= aif_pkg::aif_evt_s'(9'h040);
        flag_clr <= 13'h0040;
        @(posedge clock);
        evt      <= '0;
        flag_clr <= '0;
        #1;
        check("set beats clear", status, 32'h0000_0040);
        clear(13'h0040);
        check("set then cleared", status, 32'h0);
        // Host write to the generator changes nothing; its read value is not relied on
        @(posedge clock);
        host_wr    <= 1'b1;
        host_addr  <= aif_pkg::ADDR_CUSTOM_GEN;
        host_wdata <= 32'hFFFF_FFFF;
        @(posedge clock);
        host_wr <= 1'b0;
        #1;
        check("host write gen", gen, 32'h0000_0010);
        check("host write status", status, 32'h0);
        // Generator read over the host port is made but its value is never relied on
        host_read(aif_pkg::ADDR_CUSTOM_GEN, rd);
        i_aif_seq_model.write(16'h2098, 32'h0000_000F);
        #1;
        check("wrong addr", status, 32'h0);
        i_aif_seq_model.write(aif_pkg::ADDR_CUSTOM_GEN, 32'hFFFF_FFF0);
        #1;
        check("upper bits", gen, 32'h0000_0010);
        i_aif_seq_model.write(aif_pkg::ADDR_CUSTOM_GEN, 32'h0000_0005);
        #1;
        check("gen trig", gen, 32'h0000_0015);
        check("custom status", status, 32'h0000_0A00);
        i_aif_seq_model.write(aif_pkg::ADDR_CUSTOM_GEN, 32'h0000_000A);
        #1;
        check("custom all", status, 32'h0000_1E00);
        clear(13'h1E00);
        check("custom clear", gen, 32'h0000_0010);
        check("custom clear status", status, 32'h0);
        $display("test custom done");
        // Reset in mid-run drops every flag and trigger bit
        i_aif_seq_model.write(aif_pkg::ADDR_CUSTOM_GEN, 32'h0000_0003);
        @(posedge clock);
        evt <= aif_pkg::aif_evt_s'(9'h1FF);
        @(posedge clock);
        evt <= '0;
        #1;
        check("all flags", status, 32'h0000_07FF);
        check("gen before reset", gen, 32'h0000_0013);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        check("mid reset status", status, 32'h0);
        check("mid reset gen", gen, 32'h0000_0010);
        host_read(aif_pkg::ADDR_FLAG_STATUS_A, rd);
        check("mid reset read", rd, 32'h0);
        $display("test mid reset done");
        summarize();
    end
endmodule
